// ---- hdl/sram_pkg.sv ----
package sram_pkg;
  localparam int ADDR_W      = 18;
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int DATA_W      = LANES * LANE_W;
  localparam int DEPTH       = 1 << ADDR_W;
  localparam int BURST_W     = 2;
  localparam int FIFO_DEPTH  = 4;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_e;

  // one command as captured at the clock edge
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] data;
  } cmd_s;
endpackage

// ---- hdl/cmd_fifo.sv ----
`timescale 1ns/10ps
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW:0]      cnt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt != (PW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= PW'((wp + 1'b1) % DEPTH);
      end
      if (pop) begin
        rp <= PW'((rp + 1'b1) % DEPTH);
      end
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ---- hdl/sync_burst_sram_cycle_decode.sv ----
`timescale 1ns/10ps
// How it works
// [RULE_01] chip select high with controller strobe low: deselect, no address, bus off
// [RULE_02] chip select low, processor strobe low: read burst at external address
// [RULE_03] processor strobe high, controller strobe low: load address, write or read
// [RULE_04] no strobe, advance low, no write: step burst address and read
// [RULE_05] no strobe, advance low, write: step burst address and write data
// [RULE_06] no strobe, advance high, no write: hold address and read again
// [RULE_07] no strobe, advance high, write: hold address and write there
// [RULE_08] output enable high turns data drivers off at once, asynchronously
// [RULE_09] output enable low only passes drivers a read already turned on
// [RULE_10] controller may tie strobes for plain single-address cycles
// [RULE_11] controller may tie advance low, loading starts with controller strobe
// [RULE_12] dummy reads with output enable high still step the counter
// [RULE_13] controller may use dummy reads to turn the bus around
// [RULE_14] write true on global write low, or lane enable low with lanes
// [RULE_15] two-bit counter linear or interleaved, wraps on fifth clock
// [RULE_16] deselect latency pin low: dual-cycle, high: single-cycle deselect
// [RULE_17] sleep request holds the array idle, contents kept
// [RULE_18] read data registered one clock after the request
module sync_burst_sram_cycle_decode
  import sram_pkg::*;
(
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST,
  input  wire logic                        CHIP_SELECT_LOW,
  input  wire logic                        PROCESSOR_ADDR_STROBE,
  input  wire logic                        CONTROLLER_ADDR_STROBE,
  input  wire logic                        BURST_ADVANCE,
  input  wire logic                        GLOBAL_WRITE_ALL,
  input  wire logic                        LANE_WRITE_ENABLE,
  input  wire logic [sram_pkg::LANES-1:0]  LANE_WRITE_SELECT,
  input  wire logic                        OUTPUT_DISABLE,
  input  wire logic                        BURST_ORDER_SELECT,
  input  wire logic                        DESELECT_LATENCY_SELECT,
  input  wire logic                        SLEEP_REQUEST,
  input  wire logic [sram_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [sram_pkg::DATA_W-1:0] DQ_IN,
  output logic      [sram_pkg::DATA_W-1:0] DQ_OUT,
  output logic      [sram_pkg::DATA_W-1:0] DQ_OE,
  output logic                             CMD_STALL
);
  import sram_pkg::*;

  logic [DATA_W-1:0]  mem [DEPTH];
  logic [ADDR_W-1:0]  base_addr;
  logic [BURST_W-1:0] burst_cnt;
  logic [ADDR_W-1:0]  cur_addr;
  logic [BURST_W-1:0] next_cnt;
  logic [ADDR_W-1:0]  next_base;
  op_e                op;
  logic               load;
  logic               wr_true;
  logic [LANES-1:0]   wr_lanes;
  cmd_s               cmd_in;
  cmd_s               cmd_out;
  logic               f_valid;
  logic               f_ready;
  logic               drive_stage1;
  logic               drive_stage2;
  logic [DATA_W-1:0]  rd_data;
  logic               in_sleep;

  // burst low bits: linear adds, interleaved flips by the count
  function automatic logic [BURST_W-1:0] burst_bits(input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] cnt,
                                                    input logic inter);
    burst_bits = inter ? (start ^ cnt) : BURST_W'(start + cnt); // [RULE_15]
  endfunction

  // write qualifier and lane mask; lane 0 rides in bit 0
  always_comb begin
    wr_lanes = '0;
    if (!GLOBAL_WRITE_ALL) begin
      wr_lanes = '1; // [RULE_14]
    end else if (!LANE_WRITE_ENABLE) begin
      wr_lanes = ~LANE_WRITE_SELECT; // [RULE_14]
    end
    wr_true = |wr_lanes;
  end

  // per-cycle decode of the strobes
  always_comb begin
    load      = 1'b0;
    op        = OP_IDLE;
    next_base = base_addr;
    next_cnt  = burst_cnt;
    if (SLEEP_REQUEST) begin
      op = OP_IDLE; // [RULE_17]
    end else if (CHIP_SELECT_LOW && !CONTROLLER_ADDR_STROBE) begin
      op = OP_IDLE; // [RULE_01]
    end else if (!CHIP_SELECT_LOW && !PROCESSOR_ADDR_STROBE) begin
      load = 1'b1;
      op   = OP_READ; // [RULE_02]
    end else if (!CHIP_SELECT_LOW && !CONTROLLER_ADDR_STROBE) begin
      load = 1'b1;
      op   = wr_true ? OP_WRITE : OP_READ; // [RULE_03]
    end else if (CONTROLLER_ADDR_STROBE &&
                 (PROCESSOR_ADDR_STROBE || CHIP_SELECT_LOW)) begin
      op = wr_true ? OP_WRITE : OP_READ;
      if (!BURST_ADVANCE) begin
        next_cnt = BURST_W'(burst_cnt + 1'b1); // [RULE_04] [RULE_05] [RULE_12]
      end
      // advance high keeps the count: [RULE_06] [RULE_07]
    end
    if (load) begin
      next_base = ADDR;
      next_cnt  = '0;
    end
  end

  assign cur_addr = {next_base[ADDR_W-1:BURST_W],
                     burst_bits(next_base[BURST_W-1:0], next_cnt, BURST_ORDER_SELECT)};

  // no device reset exists; RST only clears the control pipeline
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      base_addr <= '0;
      burst_cnt <= '0;
    end else if (f_ready) begin
      base_addr <= next_base;
      burst_cnt <= next_cnt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      in_sleep <= 1'b0;
    end else begin
      in_sleep <= SLEEP_REQUEST;
    end
  end

  // writes queue in a small buffer so the array port can be stalled
  assign cmd_in.rd    = (op == OP_READ);
  assign cmd_in.wr    = (op == OP_WRITE);
  assign cmd_in.addr  = cur_addr;
  assign cmd_in.lanes = wr_lanes;
  assign cmd_in.data  = DQ_IN;
  assign CMD_STALL    = ~f_ready;

  cmd_fifo #(
    .WIDTH ($bits(cmd_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_valid  (cmd_in.wr),
    .in_ready  (f_ready),
    .in_data   (cmd_in),
    .out_valid (f_valid),
    .out_ready (~in_sleep),
    .out_data  (cmd_out)
  );

  // array write drains the buffer; sleep stalls it, contents stay
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge CLK_SYS) begin
        if (f_valid && !in_sleep && cmd_out.lanes[g]) begin
          mem[cmd_out.addr][g*LANE_W +: LANE_W] <= cmd_out.data[g*LANE_W +: LANE_W]; // [RULE_17]
        end
      end
    end
  endgenerate

  // read pipeline; a pending write to the same word forwards nothing,
  // so reads right after writes to one word need one idle cycle
  always_ff @(posedge CLK_SYS) begin
    if (cmd_in.rd && f_ready) begin
      rd_data <= mem[cur_addr]; // [RULE_18]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      drive_stage1 <= 1'b0;
      drive_stage2 <= 1'b0;
    end else begin
      drive_stage1 <= cmd_in.rd && f_ready; // [RULE_18]
      drive_stage2 <= drive_stage1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DQ_OUT <= '0;
    end else begin
      DQ_OUT <= rd_data;
    end
  end

  // single-cycle deselect drops drive one stage early
  logic drive_on;
  assign drive_on = DESELECT_LATENCY_SELECT ? (drive_stage2 & drive_stage1)
                                            : drive_stage2; // [RULE_16]
  assign DQ_OE = {DATA_W{drive_on & ~OUTPUT_DISABLE}}; // [RULE_08] [RULE_09]

  a_dummy_read_step: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_12]
    (OUTPUT_DISABLE && CONTROLLER_ADDR_STROBE && (PROCESSOR_ADDR_STROBE || CHIP_SELECT_LOW)
     && !BURST_ADVANCE && !SLEEP_REQUEST && !wr_true && f_ready)
    |=> burst_cnt == BURST_W'($past(burst_cnt) + 1'b1))
    else $error("dummy read did not step counter");

  a_oe_async_off: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_08]
    OUTPUT_DISABLE |-> DQ_OE == '0)
    else $error("drivers on while output disabled");

  a_deselect_hold: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_01]
    (CHIP_SELECT_LOW && !CONTROLLER_ADDR_STROBE) |=> ##1 !drive_stage2)
    else $error("deselect still drives");

  a_read_latency: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_18]
    (cmd_in.rd && f_ready) |=> ##1 drive_stage2)
    else $error("read data late");

  a_load_zero: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_02]
    (load && f_ready) |=> burst_cnt == '0 && base_addr == $past(ADDR))
    else $error("burst start address wrong");

  // truth-table rows: what each strobe pattern hands to the pipeline
  a_deselect_idle: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_01]
    (CHIP_SELECT_LOW && !CONTROLLER_ADDR_STROBE)
    |-> !cmd_in.rd && !cmd_in.wr && !load)
    else $error("deselect cycle used an address");

  a_read_begin: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_02]
    (!CHIP_SELECT_LOW && !PROCESSOR_ADDR_STROBE && !SLEEP_REQUEST)
    |-> load && cmd_in.rd && !cmd_in.wr)
    else $error("processor strobe did not start a read");

  a_ctrl_begin: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_03]
    (!CHIP_SELECT_LOW && PROCESSOR_ADDR_STROBE && !CONTROLLER_ADDR_STROBE && !SLEEP_REQUEST)
    |-> load && cmd_in.wr == wr_true && cmd_in.rd == !wr_true)
    else $error("controller strobe started the wrong burst");

  a_continue_step: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_04] [RULE_05]
    (CONTROLLER_ADDR_STROBE && (PROCESSOR_ADDR_STROBE || CHIP_SELECT_LOW)
     && !BURST_ADVANCE && !SLEEP_REQUEST && f_ready)
    |=> burst_cnt == BURST_W'($past(burst_cnt) + 1'b1) && base_addr == $past(base_addr))
    else $error("continue cycle did not step the burst");

  a_suspend_hold: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_06] [RULE_07]
    (CONTROLLER_ADDR_STROBE && (PROCESSOR_ADDR_STROBE || CHIP_SELECT_LOW)
     && BURST_ADVANCE && !SLEEP_REQUEST && f_ready)
    |=> burst_cnt == $past(burst_cnt) && base_addr == $past(base_addr))
    else $error("suspend cycle moved the burst address");

  // drivers only ever follow a staged read
  a_write_no_drive: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_09]
    !cmd_in.rd
    |=> ##1 !drive_stage2)
    else $error("write or idle cycle staged a drive");

  a_drive_needs_read: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_09]
    (DQ_OE != '0)
    |-> drive_stage2 && !OUTPUT_DISABLE)
    else $error("drivers on without a read");

  a_single_early: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_16]
    (DESELECT_LATENCY_SELECT && !drive_stage1)
    |-> DQ_OE == '0)
    else $error("single-cycle deselect kept driving");

  a_dual_drive: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_16]
    (!DESELECT_LATENCY_SELECT && drive_stage2 && !OUTPUT_DISABLE)
    |-> DQ_OE == '1)
    else $error("dual-cycle read not driven");

  a_lane_mask: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_14]
    (GLOBAL_WRITE_ALL && !LANE_WRITE_ENABLE)
    |-> wr_lanes == ~LANE_WRITE_SELECT)
    else $error("lane mask differs from lane selects");

  a_global_all: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_14]
    !GLOBAL_WRITE_ALL
    |-> wr_lanes == '1 && wr_true)
    else $error("global write missed a lane");

  a_read_no_lanes: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_14]
    (GLOBAL_WRITE_ALL && LANE_WRITE_ENABLE)
    |-> !wr_true)
    else $error("write qualifier true with writes off");

  a_sleep_idle: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_17]
    SLEEP_REQUEST
    |-> !cmd_in.rd && !cmd_in.wr && !load)
    else $error("command taken during sleep");

  // burst address seen from the registered base, not the decode path
  a_order_linear: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_15]
    (!BURST_ORDER_SELECT && !load)
    |-> cur_addr[BURST_W-1:0] == BURST_W'(base_addr[BURST_W-1:0] + next_cnt))
    else $error("linear burst order wrong");

  a_order_inter: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_15]
    (BURST_ORDER_SELECT && !load)
    |-> cur_addr[BURST_W-1:0] == (base_addr[BURST_W-1:0] ^ next_cnt))
    else $error("interleaved burst order wrong");

  a_upper_fixed: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_15]
    !load
    |-> cur_addr[ADDR_W-1:BURST_W] == base_addr[ADDR_W-1:BURST_W])
    else $error("burst left its four-word block");
endmodule

// ---- verification/ctrl_model.sv ----
`timescale 1ns/10ps
module ctrl_model
  import sram_pkg::*;
(
  input  wire logic                        clk,
  output logic      [9:0]                  ctl,
  output logic      [sram_pkg::ADDR_W-1:0] addr,
  output logic      [sram_pkg::DATA_W-1:0] din
);
  initial begin
    // park as a deselect so nothing is read while reset lifts
    ctl  = 10'h37f;
    addr = '0;
    din  = '0;
  end
  // unused data never repeats the last value, so stale use shows; unused address is whatever the caller passes
  task automatic put(input logic [9:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic w);
    @(negedge clk);
    ctl  = c;
    addr = a;
    din  = w ? d : ~din;
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import sram_pkg::*;
  logic              clk_sys = 0;
  logic              rst = 1;
  logic              od = 0;
  logic              ord = 0;
  logic              slp = 0;
  logic              deselect_latency_select = 0;
  logic [9:0]        ctl;
  logic [LANES-1:0]  lsel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] din, dq_out, dq_oe, wd;
  logic              stall;
  logic [DATA_W-1:0] m [16];
  logic [DATA_W-1:0] pd [2];
  int                pk [2];
  int                n_errors = 0;
  int                tests_run = 0;
  logic [1:0]        s, k;
  logic [1:0]        hi;
  localparam logic [ADDR_W-1:0] BASE = 18'h2a5c0;
  always #10 clk_sys = ~clk_sys;
  ctrl_model u_ctrl_model (.clk(clk_sys), .ctl(ctl), .addr(addr), .din(din));
  sync_burst_sram_cycle_decode u_sync_burst_sram_cycle_decode (
    .CLK_SYS(clk_sys), .RST(rst), .CHIP_SELECT_LOW(ctl[9]),
    .PROCESSOR_ADDR_STROBE(ctl[8]), .CONTROLLER_ADDR_STROBE(ctl[7]),
    .BURST_ADVANCE(ctl[6]), .GLOBAL_WRITE_ALL(ctl[5]), .LANE_WRITE_ENABLE(ctl[4]),
    .LANE_WRITE_SELECT(ctl[3:0]), .OUTPUT_DISABLE(od), .BURST_ORDER_SELECT(ord),
    .DESELECT_LATENCY_SELECT(deselect_latency_select), .SLEEP_REQUEST(slp), .ADDR(addr), .DQ_IN(din),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .CMD_STALL(stall));
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // c: 0 deselect, 1 read via processor strobe, 2 write begin, 3 read via
  // controller strobe, 4 continue read, 5 continue write, 6/7 suspend rd/wr
  task automatic op(input int c, input logic [3:0] a, input logic [3:0] o);
    logic [5:0] wq;
    logic [3:0] cur;
    logic       wr;
    logic       on;
    wq = (lsel == '0) ? 6'h1f : {2'b10, lsel};
    wr = (c == 2 || c == 5 || c == 7);
    if (c inside {1, 2, 3}) begin
      s  = a[1:0];
      hi = a[3:2];
      k  = 0;
    end
    if (c == 4 || c == 5) k++;
    cur = {hi, ord ? (s ^ k) : (s + k)};
    case (c)
      0: u_ctrl_model.put({4'b1101, 6'h3f}, ~BASE, wd, 0);
      1: u_ctrl_model.put({4'b0011, wq}, BASE | a, wd, 0);
      2: u_ctrl_model.put({4'b0100, wq}, BASE | a, wd, 1);
      3: u_ctrl_model.put({4'b0101, 6'h3f}, BASE | a, wd, 0);
      4: u_ctrl_model.put({4'b1010, 6'h3f}, ~BASE, wd, 0);
      5: u_ctrl_model.put({4'b0110, wq}, ~BASE, wd, 1);
      6: u_ctrl_model.put({4'b0111, 6'h3f}, ~BASE, wd, 0);
      default: u_ctrl_model.put({4'b1111, wq}, ~BASE, wd, 1);
    endcase
    {deselect_latency_select, ord, slp, od} = o;
    wr = wr && !slp;
    on = (pk[1] == 2) && (!deselect_latency_select || pk[0] == 2) && !od;
    #1;
    if (pk[1] == 2) check(dq_out, pd[1]);
    if (pk[1] != 0) check(dq_oe, {DATA_W{on}});
    check(DATA_W'(stall), '0);
    for (int i = 0; i < LANES; i++)
      if (wr && (lsel == '0 || !lsel[i])) m[cur][i*LANE_W +: LANE_W] = wd[i*LANE_W +: LANE_W];
    pk[1] = pk[0];
    pd[1] = pd[0];
    pk[0] = (!slp && (c inside {1, 3, 4, 6})) ? 2 : 1;
    pd[0] = m[cur];
  endtask
  task automatic t_write;
    lsel = '0;
    wd = 36'h1_1111_1110;
    op(2, 4'h0, 0);
    for (int i = 0; i < 3; i++) begin
      wd = wd + 36'h2_0401_0203;
      op(5, 4'h0, 0);
    end
    repeat (6) op(0, 4'h0, 0);
    $display("write burst test done");
  endtask
  task automatic t_reads;
    op(1, 4'h0, 0);
    repeat (4) op(4, 4'h0, 0);
    op(3, 4'h1, 4);
    repeat (3) op(4, 4'h1, 4);
    op(6, 4'h1, 4);
    repeat (3) op(0, 4'h0, 0);
    $display("read burst test done");
  endtask
  task automatic t_lane;
    wd = 36'h3_c3c3_c3c3;
    op(2, 4'h4, 0);
    lsel = 4'b1110;
    wd = 36'h9_8765_4321;
    op(2, 4'h4, 0);
    lsel = 4'b0111;
    wd = 36'h5_a5a5_a5a5;
    op(7, 4'h4, 0);
    repeat (6) op(0, 4'h0, 0);
    op(1, 4'h4, 0);
    repeat (3) op(0, 4'h0, 0);
    $display("lane write test done");
  endtask
  task automatic t_dummy;
    op(1, 4'h0, 1);
    repeat (3) op(4, 4'h0, 1);
    op(4, 4'h0, 0);
    repeat (3) op(0, 4'h0, 0);
    $display("dummy read test done");
  endtask
  task automatic t_single;
    op(3, 4'h1, 8);
    op(3, 4'h2, 8);
    repeat (2) op(4, 4'h2, 8);
    repeat (3) op(0, 4'h0, 8);
    $display("single-cycle deselect test done");
  endtask
  task automatic t_sleep;
    repeat (2) op(0, 4'h0, 2);
    wd = 36'hf_0f0f_0f0f;
    op(2, 4'h2, 2);
    op(3, 4'h2, 2);
    op(0, 4'h0, 0);
    op(3, 4'h2, 0);
    repeat (3) op(0, 4'h0, 0);
    $display("sleep test done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    foreach (m[i]) m[i] = '0;
    pk = '{0, 0};
    lsel = '0;
    wd = '0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    t_write;
    t_reads;
    t_lane;
    t_dummy;
    t_single;
    t_sleep;
    wrap_up;
  end
  // all tests take about 62 cycles; this leaves ample margin
  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule
